// ===== logic/wdtu_counter.sv
`timescale 1ns/1ps
module wdtu_counter
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controls
  input wire logic low_freq_osc_tick,
  input wire logic clear,
  input wire logic active,
  input wire logic [4:0] period_select,
  // results
  output logic [23:0] count,
  output logic timeout
);

  logic [4:0] eff_select;
  logic [23:0] last_count;
  logic wrap;

  // reserved codes fall back to the shortest interval
  always_comb
  begin
    eff_select = (period_select > wdtu_pkg::PS_MAX) ? 5'h00 // R8
      : period_select;
    last_count = 24'((25'h00_0001 << (eff_select + 5'(wdtu_pkg::BASE_LOG2)))
      - 25'h00_0001); // R7 R17
    wrap = low_freq_osc_tick && count >= last_count;
  end

  // counts oscillator ticks only; pclk rate and divider play no part
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 24'h00_0000;
    else if (clear || !active) // R10
      count <= 24'h00_0000;
    else if (wrap)
      count <= 24'h00_0000;
    else if (low_freq_osc_tick) // R2 R11
      count <= count + 24'h00_0001;
  end

  // one pulse as the selected period is reached
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timeout <= 1'b0;
    else
      timeout <= wrap && active && !clear; // R17
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_tick;
    low_freq_osc_tick && active && !clear && count >= last_count;
  endsequence

  a_period_reach: assert property (s_last_tick |=> timeout // R17
    && count == 24'h00_0000) else $error("period reached without timeout");
  a_reserved_min: assert property ((period_select > 5'h12 // R8
    && low_freq_osc_tick && active && !clear && count == 24'h00_001f)
    |=> timeout) else $error("reserved code not minimum interval");
  a_tick_only: assert property ((!low_freq_osc_tick && !clear && active) // R2
    |=> $stable(count)) else $error("counter moved without oscillator tick");
  a_clear_zero: assert property ((clear || !active) |=> count == 24'h00_0000
    && !timeout) else $error("counter not cleared"); // R10

endmodule

// ===== logic/wdtu_mode_ctrl.sv
`timescale 1ns/1ps
module wdtu_mode_ctrl
(
  // configuration
  input wire logic [1:0] watchdog_mode_cfg,
  input wire logic software_watchdog_on,
  input wire logic device_asleep,
  // result
  output logic active
);

  wdtu_pkg::wdtu_mode_type mode;

  // decode of the four enable modes
  always_comb
  begin
    mode = wdtu_pkg::wdtu_mode_type'(watchdog_mode_cfg);
    unique case (mode)
      wdtu_pkg::MODE_ALWAYS: active = 1'b1; // R3
      wdtu_pkg::MODE_AWAKE_ONLY: active = !device_asleep; // R4
      wdtu_pkg::MODE_SOFTWARE: active = software_watchdog_on; // R5
      wdtu_pkg::MODE_OFF: active = 1'b0; // R6
    endcase
    // checked after the decode in one process, so no ordering glitch
    a_mode_always: assert (watchdog_mode_cfg != 2'h3 || active) // R3
      else $error("always-on mode left watchdog inactive");
    a_mode_awake: assert (watchdog_mode_cfg != 2'h2 // R4
      || active == !device_asleep)
      else $error("awake-only mode wrong for sleep state");
    a_mode_off: assert (watchdog_mode_cfg != 2'h0 || !active) // R6
      else $error("off mode left watchdog active");
  end

endmodule

// ===== logic/wdtu_pkg.sv
package wdtu_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_POWER = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h00c;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
  localparam logic [11:0] OFS_COUNT = 12'h014;

  // watchdog_control fields
  localparam int CTRL_SW_ON_BIT = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int CTRL_PS_W = 5;
  localparam int CTRL_W = 6;
  localparam logic [4:0] PS_RESET = 5'h0b;
  localparam logic [4:0] PS_MAX = 5'h12;
  localparam logic SW_ON_RESET = 1'b0;

  // power_control_reg, status and interrupt fields
  localparam int PWR_RESET_FLAG_BIT = 4;
  localparam int STAT_EXPIRY_BIT = 4;
  localparam int STAT_PWRDN_BIT = 3;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int IRQ_W = 2;
  localparam int IRQ_RESET_EV_BIT = 0;
  localparam int IRQ_WAKE_EV_BIT = 1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // oscillator time base: 31 kHz source, 1 ms base interval
  localparam int LFOSC_HZ = 31000;
  localparam int BASE_INTERVAL_US = 1000;
  localparam int BASE_LOG2 = 5;
  localparam int BASE_TICKS = 1 << BASE_LOG2;
  localparam int CNT_W = 24;

  // enable modes in configuration order 00, 01, 10, 11
  typedef enum logic [1:0]
  {
    MODE_OFF,
    MODE_SOFTWARE,
    MODE_AWAKE_ONLY,
    MODE_ALWAYS
  } wdtu_mode_type;

endpackage

// ===== logic/wdtu_top.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Functional notes
// R1 - awake and active: reaching the period without a clear requests reset
// R2 - counter advances only on low-frequency oscillator ticks, 1 ms base
// R3 - mode 11: always active, sleep included, software bit ignored
// R4 - mode 10: active awake, disabled in sleep, software bit ignored
// R5 - mode 01: software bit turns watchdog on or off, sleep irrelevant
// R6 - mode 00: always disabled, software bit ignored
// R7 - period code 0 is 1:32, each step doubles, up to code 18
// R8 - reserved codes 19 to 31 act as the 1:32 minimum
// R9 - any reset loads period code 01011, the 2 s interval
// R10 - counter clears on reset, clear, sleep edges, osc fail, disable
// R11 - oscillator divider changes leave the counter alone
// R12 - sleep entry clears; counting goes on if enabled; exit clears again
// R13 - timeout in sleep wakes the device instead of resetting
// R14 - watchdog event sets the reset indicator in the power register
// R15 - control bits 7 and 6 read zero; software enable resets to 0
// R16 - wake after sleep sets expiry flag and clears power-down flag
// R17 - timeout when tick count reaches two to the five plus code
module wdtu_top
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor core and reset controller
  input wire logic [1:0] watchdog_mode_cfg,
  input wire logic low_freq_osc_tick,
  input wire logic watchdog_clear_instr,
  input wire logic device_asleep,
  input wire logic interrupt_wake,
  input wire logic osc_fail,
  input wire logic device_reset_in,
  output logic device_reset_req,
  output logic wake_req,
  output logic expiry_flag_n,
  output logic powerdown_flag_n,
  output logic watchdog_active,
  // interrupt
  output logic irq
);

  logic [4:0] period_select;
  logic software_watchdog_on;
  logic watchdog_reset_flag;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic asleep_q;
  logic sleep_enter;
  logic sleep_exit;
  logic counter_clear;
  logic active;
  logic timeout;
  logic [23:0] count;
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic [31:0] next_rdata;
  logic next_err;
  logic [1:0] irq_set;

  // sleep edges taken from the core's sleep level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      asleep_q <= 1'b0;
    else
      asleep_q <= device_asleep;
  end

  // sleep edge decode and every source of a counter clear
  assign sleep_enter = device_asleep && !asleep_q;
  assign sleep_exit = !device_asleep && asleep_q;
  assign counter_clear = watchdog_clear_instr || sleep_enter // R10 R12
    || sleep_exit || osc_fail || device_reset_in;

  wdtu_mode_ctrl u_mode
  (
    .watchdog_mode_cfg(watchdog_mode_cfg),
    .software_watchdog_on(software_watchdog_on),
    .device_asleep(device_asleep),
    .active(active)
  );

  // no divider input at all, so its changes cannot disturb the count
  wdtu_counter u_counter
  (
    .pclk(pclk),
    .presetn(presetn),
    .low_freq_osc_tick(low_freq_osc_tick),
    .clear(counter_clear),
    .active(active),
    .period_select(period_select),
    .count(count),
    .timeout(timeout)
  );

  // apb handshake: one wait state, answer registered
  assign setup_phase = psel && penable && !pready;
  assign access_done = psel && penable && pready;
  assign wr_en = access_done && pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup_phase;
  end

  // read mux; unmapped offsets answer zero with an error
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    unique case (paddr)
      wdtu_pkg::OFS_CONTROL:
      begin
        next_rdata[wdtu_pkg::CTRL_PS_LSB +: wdtu_pkg::CTRL_PS_W] =
          period_select;
        next_rdata[wdtu_pkg::CTRL_SW_ON_BIT] = software_watchdog_on;
      end
      wdtu_pkg::OFS_POWER:
        next_rdata[wdtu_pkg::PWR_RESET_FLAG_BIT] = watchdog_reset_flag;
      wdtu_pkg::OFS_STATUS:
      begin
        next_rdata[wdtu_pkg::STAT_EXPIRY_BIT] = expiry_flag_n;
        next_rdata[wdtu_pkg::STAT_PWRDN_BIT] = powerdown_flag_n;
        next_rdata[wdtu_pkg::STAT_ACTIVE_BIT] = active;
      end
      wdtu_pkg::OFS_IRQ_STAT:
        next_rdata[wdtu_pkg::IRQ_W - 1:0] = irq_stat;
      wdtu_pkg::OFS_IRQ_MASK:
        next_rdata[wdtu_pkg::IRQ_W - 1:0] = irq_mask;
      wdtu_pkg::OFS_COUNT:
        next_rdata[wdtu_pkg::CNT_W - 1:0] = count;
      default:
        next_err = 1'b1;
    endcase
  end

  // answer data and error latched with the ready flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end
    else
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // control register; any device reset restores its defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      period_select <= wdtu_pkg::PS_RESET; // R9
      software_watchdog_on <= wdtu_pkg::SW_ON_RESET; // R15
    end
    else if (device_reset_in)
    begin
      period_select <= wdtu_pkg::PS_RESET; // R9
      software_watchdog_on <= wdtu_pkg::SW_ON_RESET; // R15
    end
    else if (wr_en && paddr == wdtu_pkg::OFS_CONTROL)
    begin
      period_select <=
        pwdata[wdtu_pkg::CTRL_PS_LSB +: wdtu_pkg::CTRL_PS_W];
      software_watchdog_on <= pwdata[wdtu_pkg::CTRL_SW_ON_BIT]; // R5
    end
  end

  // reset indicator: set on every watchdog event, write one to clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_reset_flag <= 1'b0;
    else if (timeout) // R14
      watchdog_reset_flag <= 1'b1;
    else if (wr_en && paddr == wdtu_pkg::OFS_POWER
      && pwdata[wdtu_pkg::PWR_RESET_FLAG_BIT])
      watchdog_reset_flag <= 1'b0;
  end

  // awake timeout resets, sleeping timeout only wakes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      device_reset_req <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      device_reset_req <= timeout && !device_asleep; // R1
      wake_req <= timeout && device_asleep; // R13
    end
  end

  // active-low status flags; survive device resets, only presetn inits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      expiry_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end
    else if (timeout && device_asleep)
    begin
      expiry_flag_n <= 1'b0; // R13
      powerdown_flag_n <= 1'b0;
    end
    else if (timeout)
    begin
      expiry_flag_n <= 1'b0;
      powerdown_flag_n <= 1'b1;
    end
    else if (sleep_enter)
    begin
      expiry_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b0;
    end
    else if (interrupt_wake && device_asleep)
    begin
      expiry_flag_n <= 1'b1; // R16
      powerdown_flag_n <= 1'b0; // R16
    end
  end

  // sticky events; a set in the clearing cycle wins
  assign irq_set = {timeout && device_asleep, timeout && !device_asleep};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= 2'h0;
    else if (wr_en && paddr == wdtu_pkg::OFS_IRQ_STAT)
      irq_stat <= (irq_stat & ~pwdata[wdtu_pkg::IRQ_W - 1:0]) | irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end

  // interrupt mask register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= wdtu_pkg::IRQ_MASK_RESET;
    else if (wr_en && paddr == wdtu_pkg::OFS_IRQ_MASK)
      irq_mask <= pwdata[wdtu_pkg::IRQ_W - 1:0];
  end

  // level interrupt and active indication, registered for clean outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
      watchdog_active <= 1'b0;
    end
    else
    begin
      irq <= |((irq_stat | irq_set) & irq_mask);
      watchdog_active <= active;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctrl_read;
    setup_phase && !pwrite && paddr == wdtu_pkg::OFS_CONTROL;
  endsequence

  sequence s_awake_expiry;
    timeout && !device_asleep;
  endsequence

  sequence s_sleep_expiry;
    timeout && device_asleep;
  endsequence

  a_awake_reset: assert property (s_awake_expiry |=> device_reset_req // R1
    && !wake_req ##1 !device_reset_req)
    else $error("awake expiry did not pulse reset request");
  a_sleep_wake: assert property (s_sleep_expiry |=> wake_req // R13
    && !device_reset_req && !expiry_flag_n && !powerdown_flag_n)
    else $error("sleep expiry did not wake with flags");
  a_event_flag: assert property (timeout |=> watchdog_reset_flag) // R14
    else $error("reset indicator not set on watchdog event");
  a_ctrl_upper: assert property (s_ctrl_read |=> pready // R15
    && prdata[31:6] == 26'h000_0000)
    else $error("control upper bits not zero");
  a_reset_default: assert property (device_reset_in |=> // R9
    period_select == 5'h0b && !software_watchdog_on)
    else $error("device reset did not restore control");
  a_sw_disable: assert property ((watchdog_mode_cfg == 2'h1 // R5
    && !software_watchdog_on) |=> !watchdog_active)
    else $error("software-off mode left watchdog active");
  a_sleep_clear: assert property ((sleep_enter || sleep_exit) // R12
    |=> count == 24'h00_0000) else $error("sleep edge did not clear");
  a_wake_flags: assert property ((interrupt_wake && device_asleep // R16
    && !timeout && !sleep_enter) |=> expiry_flag_n && !powerdown_flag_n)
    else $error("wake flags wrong");
  a_irq_follow: assert property ((irq_stat & irq_mask) != 2'h0 // R14
    |=> irq) else $error("unmasked event not raising interrupt");

endmodule

// ===== sim/tb_wdtu_top.sv
`timescale 1ns/1ps
module tb_wdtu_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] mode = 2'b00;
  logic clr = 1'b0;
  logic osc_fail = 1'b0;
  logic tick_run = 1'b0;
  logic sleep_cmd = 1'b0;
  logic iwake = 1'b0;
  logic tick, asleep, dev_rst, rst_req, wake_req;
  logic exp_n, pd_n, active, irq, perr, want;
  logic [31:0] q, c1;
  logic [1:0] msk = 2'b00;
  logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1f};
  int err_total = 0;
  int compares = 0;
  int tk = 0, d1 = 0, d2 = 0, base = 0, seen = 0;

  always #12.5 pclk = ~pclk;

  wdtu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_mode_cfg(mode), .low_freq_osc_tick(tick),
    .watchdog_clear_instr(clr), .device_asleep(asleep),
    .interrupt_wake(iwake), .osc_fail(osc_fail), .device_reset_in(dev_rst),
    .device_reset_req(rst_req), .wake_req(wake_req),
    .expiry_flag_n(exp_n), .powerdown_flag_n(pd_n),
    .watchdog_active(active), .irq(irq));

  wdtu_core_model i_core (.pclk(pclk), .presetn(presetn),
    .tick_run(tick_run), .sleep_cmd(sleep_cmd), .interrupt_wake(iwake),
    .device_reset_req(rst_req), .wake_req(wake_req),
    .low_freq_osc_tick(tick), .device_asleep(asleep),
    .device_reset_in(dev_rst));

  // tick tally; a request is seen two edges after the final tick
  always @(posedge pclk)
  begin
    if (rst_req === 1'b1 || wake_req === 1'b1)
      seen = d2 - base;
    if (clr)
      base = tk + tick;
    d2 = d1;
    tk = tk + tick;
    d1 = tk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  // one transfer, entered just after an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
  begin
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    perr = pslverr;
    if (n >= 20)
      err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask

  // arm a period, clear, then count ticks to the request
  task automatic expire(input logic [4:0] code, input logic slp);
    int n;
    int ex;
    logic wk;
  begin
    ex = (code > wdtu_pkg::PS_MAX) ? wdtu_pkg::BASE_TICKS
      : wdtu_pkg::BASE_TICKS << code;
    apb(1'b1, wdtu_pkg::OFS_CONTROL, {26'h0, code, 1'b1});
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rst_req !== 1'b1 && wake_req !== 1'b1 && n < 5000);
    if (n >= 5000)
      err_total++;
    wk = wake_req;
    @(posedge pclk);
    chk(seen, ex);
    chk({wk, exp_n, pd_n}, {slp, 1'b0, ~slp});
    apb(1'b0, wdtu_pkg::OFS_IRQ_STAT, 32'h0);
    chk(q, {30'h0, slp, ~slp});
    chk(irq, |(msk & {slp, ~slp}));
    apb(1'b1, wdtu_pkg::OFS_IRQ_STAT, q);
    @(posedge pclk);
    chk(irq, 1'b0);
    if (!slp)
    begin
      apb(1'b0, wdtu_pkg::OFS_POWER, 32'h0);
      chk(q, 32'h0000_0010);
      apb(1'b1, wdtu_pkg::OFS_POWER, 32'h0000_0010);
      apb(1'b0, wdtu_pkg::OFS_CONTROL, 32'h0);
      chk(q, 32'h0000_0016);
    end
  end
  endtask

  task automatic finish_test;
  begin
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    tick_run <= 1'b1;
    apb(1'b0, wdtu_pkg::OFS_CONTROL, 32'h0);
    chk(q, 32'h0000_0016);
    apb(1'b0, wdtu_pkg::OFS_STATUS, 32'h0);
    chk(q, 32'h0000_0018);
    apb(1'b0, 12'h018, 32'h0);
    chk({perr, q[30:0]}, 32'h8000_0000);
    apb(1'b1, wdtu_pkg::OFS_CONTROL, 32'hffff_ffff);
    apb(1'b0, wdtu_pkg::OFS_CONTROL, 32'h0);
    chk(q, 32'h0000_003f);
    // every mode, software bit and sleep state
    for (int s = 0; s < 2; s++)
      for (int m = 0; m < 4; m++)
        for (int w = 0; w < 2; w++)
        begin
          sleep_cmd <= s[0];
          mode <= m[1:0];
          apb(1'b1, wdtu_pkg::OFS_CONTROL, {26'h0, wdtu_pkg::PS_RESET, w[0]});
          repeat (3) @(posedge pclk);
          want = (m == 3) || (m == 2 && s == 0) || (m == 1 && w == 1);
          chk(active, want);
          apb(1'b0, wdtu_pkg::OFS_COUNT, 32'h0);
          if (!want)
            chk(q, 32'h0);
        end
    sleep_cmd <= 1'b0;
    mode <= 2'b01;
    foreach (codes[i])
    begin
      expire(codes[i], 1'b0);
      msk = 2'b11;
      apb(1'b1, wdtu_pkg::OFS_IRQ_MASK, 32'h0000_0003);
    end
    // counter holds without ticks, then the clear instruction and osc_fail each zero it
    apb(1'b1, wdtu_pkg::OFS_CONTROL, {26'h0, wdtu_pkg::PS_RESET, 1'b1});
    repeat (20) @(posedge pclk);
    tick_run <= 1'b0;
    apb(1'b0, wdtu_pkg::OFS_COUNT, 32'h0);
    c1 = q;
    chk(c1 == 32'h0, 1'b0);
    repeat (6) @(posedge pclk);
    apb(1'b0, wdtu_pkg::OFS_COUNT, 32'h0);
    chk(q, c1);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b0, wdtu_pkg::OFS_COUNT, 32'h0);
    chk(q, 32'h0);
    tick_run <= 1'b1;
    repeat (20) @(posedge pclk);
    osc_fail <= 1'b1;
    apb(1'b0, wdtu_pkg::OFS_COUNT, 32'h0);
    chk(q, 32'h0);
    osc_fail <= 1'b0;
    // expiry while asleep wakes instead of resetting
    mode <= 2'b11;
    sleep_cmd <= 1'b1;
    repeat (3) @(posedge pclk);
    expire(5'h00, 1'b1);
    mode <= 2'b00;
    sleep_cmd <= 1'b0;
    repeat (2) @(posedge pclk);
    // interrupt wake from sleep with the watchdog off
    sleep_cmd <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(asleep, 1'b1);
    iwake <= 1'b1;
    @(posedge pclk);
    iwake <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({asleep, exp_n, pd_n, wake_req, rst_req}, 5'b0_1000);
    sleep_cmd <= 1'b0;
    finish_test;
  end

  // hang guard, well past the expected run
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    finish_test;
  end
endmodule

// ===== sim/wdtu_core_model.sv
`timescale 1ns/1ps
module wdtu_core_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench controls
  input wire logic tick_run,
  input wire logic sleep_cmd,
  input wire logic interrupt_wake,
  // watchdog requests
  input wire logic device_reset_req,
  input wire logic wake_req,
  // core and oscillator outputs
  output logic low_freq_osc_tick,
  output logic device_asleep,
  output logic device_reset_in
);
  logic wake_hold;

  // tick every second cycle: far faster than silicon, counts stay exact
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_freq_osc_tick <= 1'b0;
    else
      low_freq_osc_tick <= tick_run & ~low_freq_osc_tick;
  end

  // a wake keeps the core up until the sleep command drops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      device_asleep <= 1'b0;
      wake_hold <= 1'b0;
    end
    else if (!sleep_cmd)
    begin
      device_asleep <= 1'b0;
      wake_hold <= 1'b0;
    end
    else if (wake_req | interrupt_wake)
    begin
      device_asleep <= 1'b0;
      wake_hold <= 1'b1;
    end
    else
      device_asleep <= ~wake_hold;
  end

  // reset controller answers a request with a one-cycle reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      device_reset_in <= 1'b0;
    else
      device_reset_in <= device_reset_req;
  end
endmodule
